/* File: verilog/ecl_loader.sv */
// ecl_loader: post-reset loader of the external memory interface setup.
// assumes: APB master on i_clk; reference clock, cfg_serial_in and
// wait_request arrive asynchronously on pins.
//
// Behaviour
// - after reset, sample config input in an internal then external scan.
// - internal scan spans 64 reference periods inside a 144-period window.
// - all lines start high; from data line 0, each falls two periods apart.
// - input following a scan line selects that line's preset.
// - default preset is the top address line one, also when input tied high.
// - only 17 selections are valid; anything else keeps the default.
// - a preset gives six state lengths, four coefficients, write type, refresh.
// - presets of address lines eight and nine carry no refresh interval.
// - input low until data line 0 falls requests an external configuration.
// - external scan always runs; its result is dropped after a valid preset.
// - external scan is 36 default-timed reads, one config bit each.
// - external reads address fixed words near the top of memory.
// - first twelve bits form six 2-bit extra-period fields, LSB first.
// - next twenty bits form four 5-bit strobe fields of 0 to 31.
// - then refresh interval and enable; last bit selects late write.
// - an all-low external scan gives maximum settings, refresh 72, late write.
// - an extra period after state six aligns state one to a clock rise.
// - after wait states, state five is aligned to a rising processor clock.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module ecl_loader
	import ecl_pkg::*;
(
	input wire logic i_clk, // 40 MHz system clock
	input wire logic i_rst, // synchronous reset, high
	input wire logic i_ref_clk, // reference clock pin
	input wire logic i_cfg_serial_in, // configuration input pin
	input wire logic i_wait_request, // wait pin from memory
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB write
	input wire logic [11:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error
	output logic [31:0] o_addr_data_lines, // scan line levels, then external read addresses
	output logic o_addr_data_oe, // drive enable of the lines
	output logic o_processor_clock_out, // processor clock
	output logic [17:0] o_state_lens, // six 3-bit state lengths, first at 0
	output logic [19:0] o_strobe_coefs, // four 5-bit coefficients
	output logic o_late_write, // late write selected
	output logic o_refresh_en, // refresh enabled
	output logic [7:0] o_refresh_ival, // refresh interval, reference cycles
	output logic [3:0] o_proc_cycles, // processor cycles per access
	output logic o_cfg_done // configuration loaded
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic ref_tick;
	logic cfg_s;
	logic wait_s;

	ecl_sync u_ref_sync (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_ref_clk),
		.o_level(), .o_rise(ref_tick));
	ecl_sync u_cfg_sync (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_cfg_serial_in),
		.o_level(cfg_s), .o_rise());
	ecl_sync u_wait_sync (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_wait_request),
		.o_level(wait_s), .o_rise());

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ecl_state_t st;
	ecl_state_t next_st;
	ecl_phase_t phase;
	ecl_phase_t next_phase;
	logic [7:0] win_cnt;
	logic [3:0] tm_div;
	logic pclk;
	logic pre_low;
	logic found;
	logic [4:0] sel;
	logic int_valid;
	logic ext_req;
	logic ext_used;
	logic [2:0] tidx;
	logic [2:0] next_tidx;
	logic [1:0] tcnt;
	logic [1:0] next_tcnt;
	logic [5:0] word;
	logic [3:0] wref;
	logic [35:0] ext_bits;
	logic wait_limit_en;
	logic [31:0] lines_val;
	logic [31:0] low_mask;

	// ------------------------------------------------------------
	// preset table
	// ------------------------------------------------------------
	function automatic logic [33:0] preset(input logic [4:0] k);
		case (k)
			5'h00: preset = mk(1, 1, 1, 1, 1, 1, 30, 1, 3, 5, 1'b1, 1'b1);
			5'h01: preset = mk(1, 2, 1, 1, 1, 2, 30, 1, 2, 7, 1'b1, 1'b1);
			5'h02: preset = mk(1, 2, 1, 1, 2, 3, 30, 1, 2, 7, 1'b1, 1'b1);
			5'h03: preset = mk(2, 3, 1, 1, 2, 3, 30, 1, 3, 8, 1'b1, 1'b1);
			5'h04: preset = mk(1, 1, 1, 1, 1, 1, 3, 1, 2, 3, 1'b0, 1'b1);
			5'h05: preset = mk(1, 1, 2, 1, 2, 1, 5, 1, 2, 3, 1'b0, 1'b1);
			5'h06: preset = mk(2, 1, 2, 1, 3, 1, 6, 1, 2, 3, 1'b0, 1'b1);
			5'h07: preset = mk(2, 2, 2, 1, 3, 2, 7, 1, 3, 4, 1'b0, 1'b1);
			5'h08: preset = mk(1, 1, 1, 1, 1, 1, 30, 1, 2, 3, 1'b0, 1'b0);
			5'h09: preset = mk(1, 1, 2, 1, 2, 1, 30, 2, 5, 9, 1'b0, 1'b0);
			5'h0A: preset = mk(2, 2, 2, 2, 4, 2, 30, 2, 3, 8, 1'b1, 1'b1);
			5'h0B: preset = mk(3, 3, 3, 3, 3, 3, 30, 2, 4, 13, 1'b1, 1'b1);
			5'h0C: preset = mk(1, 1, 2, 1, 2, 1, 4, 1, 2, 3, 1'b0, 1'b1);
			5'h0D: preset = mk(2, 1, 2, 1, 2, 2, 5, 1, 2, 3, 1'b0, 1'b1);
			5'h0E: preset = mk(2, 2, 2, 1, 3, 2, 6, 1, 3, 4, 1'b0, 1'b1);
			5'h0F: preset = mk(2, 1, 2, 3, 3, 3, 8, 1, 2, 3, 1'b0, 1'b1);
			default: preset = PRESET_DEFAULT;
		endcase
	endfunction

	// ------------------------------------------------------------
	// processor clock and half-cycle tick
	// ------------------------------------------------------------
	wire tm_tick = (tm_div == TM_DIV_LAST);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			tm_div <= 4'h0;
			pclk <= 1'b0;
		end
		else
		begin
			tm_div <= tm_tick ? 4'h0 : tm_div + 4'h1;
			pclk <= pclk ^ tm_tick;
		end
	end

	// ------------------------------------------------------------
	// internal scan window
	// ------------------------------------------------------------
	wire in_win = (st == ST_WIN);
	wire [7:0] rel = win_cnt - SCAN_OFS;
	wire pre_hit = in_win && ref_tick && (win_cnt == SCAN_OFS);
	wire line_hit = in_win && ref_tick && (win_cnt > SCAN_OFS) && (win_cnt < SCAN_END) && rel[0];
	wire sel_ok = (sel <= SEL_LAST_VALID) || (sel == SEL_TOP_LINE);
	wire int_ok = !pre_low && found && sel_ok;
	wire win_done = in_win && (win_cnt == WIN_LEN) && tm_tick && !pclk;

	always_comb
	begin
		for (int k = 0; k < 32; k++)
		begin
			low_mask[k] = (win_cnt >= SCAN_OFS + 8'(2 * k + 1));
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			win_cnt <= 8'h00;
			pre_low <= 1'b0;
			found <= 1'b0;
			sel <= SEL_TOP_LINE;
		end
		else
		begin
			if (in_win && ref_tick && win_cnt != WIN_LEN)
			begin
				win_cnt <= win_cnt + 8'h01;
			end
			if (pre_hit)
			begin
				pre_low <= !cfg_s;
			end
			if (line_hit && !found && !pre_low && !cfg_s)
			begin
				found <= 1'b1;
				sel <= rel[5:1];
			end
		end
	end

	// ------------------------------------------------------------
	// external scan read cycles
	// ------------------------------------------------------------
	wire in_ext = (st == ST_EXT) && tm_tick;
	wire state_end = (phase == PH_STATE) && (tcnt == TM_LAST);
	wire limit_hit = wait_limit_en && (wref == WAIT_MAX_REF);
	wire leave_wait = (phase == PH_WAIT) && (!wait_s || limit_hit);
	wire cyc_end = in_ext && ((state_end && tidx == T6_IDX && !pclk) || phase == PH_EDGE);
	wire fin = cyc_end && (word == EXT_LAST);
	wire capture = in_ext && state_end && (tidx == T5_IDX);

	always_comb
	begin
		next_phase = phase;
		next_tidx = tidx;
		next_tcnt = tcnt;
		if (cyc_end)
		begin
			next_phase = PH_STATE;
			next_tidx = 3'h0;
			next_tcnt = 2'h0;
		end
		else if (in_ext)
		begin
			case (phase)
				PH_STATE:
				begin
					next_tcnt = tcnt + 2'h1;
					if (state_end && tidx == T4_IDX && wait_s)
					begin
						next_phase = PH_WAIT;
					end
					else if (state_end && tidx == T6_IDX)
					begin
						next_phase = PH_EDGE;
					end
					else if (state_end)
					begin
						next_tidx = tidx + 3'h1;
					end
				end
				PH_WAIT:
				begin
					if (leave_wait && pclk)
					begin
						next_phase = PH_ALIGN;
					end
					else if (leave_wait)
					begin
						next_phase = PH_STATE;
						next_tidx = T5_IDX;
					end
				end
				PH_ALIGN:
				begin
					next_phase = PH_STATE;
					next_tidx = T5_IDX;
				end
				default:
				begin
					next_phase = PH_STATE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			phase <= PH_STATE;
			tidx <= 3'h0;
			tcnt <= 2'h0;
			word <= 6'h00;
			wref <= 4'h0;
			ext_bits <= 36'h0;
		end
		else
		begin
			phase <= next_phase;
			tidx <= next_tidx;
			tcnt <= next_tcnt;
			if (cyc_end && !fin)
			begin
				word <= word + 6'h01;
			end
			if (phase != PH_WAIT)
			begin
				wref <= 4'h0;
			end
			else if (ref_tick && wref != WAIT_MAX_REF)
			begin
				wref <= wref + 4'h1;
			end
			if (capture)
			begin
				ext_bits[word] <= !cfg_s;
			end
		end
	end

	// ------------------------------------------------------------
	// sequence and configuration load
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		case (st)
			ST_WIN: next_st = win_done ? ST_EXT : ST_WIN;
			ST_EXT: next_st = fin ? ST_DONE : ST_EXT;
			ST_DONE: next_st = ST_DONE;
			default: next_st = ST_WIN;
		endcase
	end

	wire load_ext = fin && ext_req;
	wire [33:0] int_pick = int_ok ? preset(sel) : PRESET_DEFAULT;
	// bit order follows the scan: fields LSB first, late write last
	wire [33:0] ext_pick = {ext_bits[11:0], ext_bits[31:12], ext_bits[35], ext_bits[34]};
	wire [7:0] ext_ival = REF_IVAL_TABLE[8 * ext_bits[33:32] +: 8];
	wire [33:0] pick = load_ext ? ext_pick : int_pick;
	wire [7:0] pick_ival = !pick[0] ? 8'h00 : (load_ext ? ext_ival : REFRESH_IVAL);
	wire [17:0] pick_lens = to_lens(pick[33:22]);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st <= ST_WIN;
			int_valid <= 1'b0;
			ext_req <= 1'b0;
			ext_used <= 1'b0;
		end
		else
		begin
			st <= next_st;
			if (win_done)
			begin
				int_valid <= int_ok;
				ext_req <= pre_low;
			end
			ext_used <= ext_used || load_ext;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_state_lens <= LENS_ALL_FOUR;
			o_strobe_coefs <= PRESET_DEFAULT[21:2];
			o_late_write <= PRESET_DEFAULT[1];
			o_refresh_en <= PRESET_DEFAULT[0];
			o_refresh_ival <= REFRESH_IVAL;
			o_proc_cycles <= cycles(LENS_ALL_FOUR);
		end
		else if (win_done || load_ext)
		begin
			o_state_lens <= pick_lens;
			o_strobe_coefs <= pick[21:2];
			o_late_write <= pick[1];
			o_refresh_en <= pick[0];
			o_refresh_ival <= pick_ival;
			o_proc_cycles <= cycles(pick_lens);
		end
	end

	// ------------------------------------------------------------
	// bus lines
	// ------------------------------------------------------------
	wire ext_addr_on = (st == ST_EXT) && (phase == PH_STATE) && (tidx <= 3'h1);
	wire [31:0] ext_addr = EXT_BASE + {24'h0, word, 2'h0};
	assign lines_val = in_win ? ~low_mask : (ext_addr_on ? ext_addr : 32'h0);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_addr_data_lines <= 32'h0;
			o_addr_data_oe <= 1'b0;
		end
		else
		begin
			o_addr_data_lines <= lines_val;
			o_addr_data_oe <= (in_win && win_cnt < SCAN_END) || ext_addr_on;
		end
	end

	assign o_processor_clock_out = pclk;
	assign o_cfg_done = (st == ST_DONE);

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	wire hit_ctrl = (i_paddr == REG_CTRL);
	wire hit_status = (i_paddr == REG_STATUS);
	wire hit_timing = (i_paddr == REG_TIMING);
	wire hit_strobe = (i_paddr == REG_STROBE);
	wire hit_refresh = (i_paddr == REG_REFRESH);
	wire mapped = hit_ctrl || hit_status || hit_timing || hit_strobe || hit_refresh;
	wire [31:0] rd_status = {19'h0, sel, 4'h0, ext_req, ext_used, int_valid, o_cfg_done};
	wire [31:0] rd_timing = {4'h0, o_proc_cycles, 3'h0, o_late_write, 2'h0, o_state_lens};
	wire [31:0] rd_val = hit_ctrl ? {31'h0, wait_limit_en} :
		hit_status ? rd_status :
		hit_timing ? rd_timing :
		hit_strobe ? {12'h0, o_strobe_coefs} :
		hit_refresh ? {23'h0, o_refresh_en, o_refresh_ival} : 32'h0;

	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_prdata <= 32'h0;
			wait_limit_en <= CTRL_WAIT_LIMIT_RST;
		end
		else
		begin
			if (i_psel && !i_penable && !i_pwrite)
			begin
				o_prdata <= rd_val;
			end
			if (i_psel && i_penable && i_pwrite && hit_ctrl)
			begin
				wait_limit_en <= i_pwdata[CTRL_WAIT_LIMIT_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	chk_scan_span: assert property (
		in_win && o_addr_data_oe |-> $past(win_cnt) < SCAN_END)
		else $error("scan lines driven past scan end");
	chk_line_order: assert property (
		$fell(o_addr_data_lines[1]) && in_win |-> !o_addr_data_lines[0] && o_addr_data_lines[2])
		else $error("scan lines fall out of order");
	chk_default_cfg: assert property (
		$rose(o_cfg_done) && !int_valid && !ext_used |=> o_state_lens == LENS_ALL_FOUR
		&& o_strobe_coefs == PRESET_DEFAULT[21:2] && o_proc_cycles == 4'hC)
		else $error("default configuration not kept");
	chk_static_noref: assert property (
		o_cfg_done && int_valid && (sel == SEL_STATIC_A || sel == SEL_STATIC_B)
		|-> !o_refresh_en && o_refresh_ival == 8'h00)
		else $error("static preset carries refresh");
	chk_ext_discard: assert property (
		int_valid |-> !ext_used)
		else $error("external result used after valid preset");
	chk_ext_words: assert property (
		$rose(o_cfg_done) |-> $past(word) == EXT_LAST)
		else $error("external scan word count wrong");
	chk_ext_addr: assert property (
		(st == ST_EXT) && $rose(o_addr_data_oe) |-> o_addr_data_lines == EXT_BASE + {24'h0, word, 2'h0})
		else $error("external scan address wrong");
	chk_t1_rise: assert property (
		cyc_end && !fin |=> pclk)
		else $error("first state not on a rising clock");
	chk_t5_rise: assert property (
		phase == PH_ALIGN && tm_tick |=> pclk && tidx == T5_IDX)
		else $error("fifth state not aligned after wait");
	chk_wait_limit: assert property (
		phase == PH_WAIT && wait_limit_en && wref == WAIT_MAX_REF && tm_tick |=> phase != PH_WAIT)
		else $error("wait stretched beyond limit");
	chk_cfg_hold: assert property (
		o_cfg_done && $past(o_cfg_done) |-> $stable(o_state_lens) && $stable(o_late_write))
		else $error("configuration changed after load");

endmodule // ecl_loader

/* File: inc/ecl_pkg.sv */
// ecl_pkg: constants, types and shared functions of the memory
// interface configuration loader.
// assumes: one 40 MHz clock and a half_cycle_period of one clock period.
package ecl_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int HALF_CYCLE_NS = 25;
	localparam int HALF_CYCLE_CYC = (HALF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] TM_DIV_LAST = 4'(HALF_CYCLE_CYC - 1);

	// ------------------------------------------------------------
	// internal scan, counted in reference_clock_period units
	// ------------------------------------------------------------
	localparam logic [7:0] WIN_LEN = 8'h90;
	localparam logic [7:0] SCAN_OFS = 8'h28;
	localparam logic [7:0] SCAN_LEN = 8'h40;
	localparam logic [7:0] SCAN_END = SCAN_OFS + SCAN_LEN;
	localparam logic [4:0] SEL_LAST_VALID = 5'h0F;
	localparam logic [4:0] SEL_TOP_LINE = 5'h1F;
	localparam logic [4:0] SEL_STATIC_A = 5'h08;
	localparam logic [4:0] SEL_STATIC_B = 5'h09;

	// ------------------------------------------------------------
	// external scan
	// ------------------------------------------------------------
	localparam logic [5:0] EXT_LAST = 6'h23;
	localparam logic [31:0] EXT_BASE = 32'h7FFFFF6C;
	localparam logic [1:0] TM_LAST = 2'h3;
	localparam logic [2:0] T4_IDX = 3'h3;
	localparam logic [2:0] T5_IDX = 3'h4;
	localparam logic [2:0] T6_IDX = 3'h5;
	localparam logic [3:0] WAIT_MAX_REF = 4'hE;
	localparam logic [7:0] REFRESH_IVAL = 8'h48;
	localparam logic [31:0] REF_IVAL_TABLE = {8'h48, 8'h36, 8'h24, 8'h12};
	localparam logic [17:0] LENS_ALL_FOUR = 18'h24924;

	// ------------------------------------------------------------
	// register map (byte offsets) and fields
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_TIMING = 12'h008;
	localparam logic [11:0] REG_STROBE = 12'h00C;
	localparam logic [11:0] REG_REFRESH = 12'h010;
	localparam int CTRL_WAIT_LIMIT_BIT = 0;
	localparam logic CTRL_WAIT_LIMIT_RST = 1'h1;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_WIN = 2'h0, ST_EXT = 2'h1, ST_DONE = 2'h3} ecl_state_t;
	typedef enum logic [1:0] {
		PH_STATE = 2'h0,
		PH_WAIT = 2'h1,
		PH_ALIGN = 2'h3,
		PH_EDGE = 2'h2
	} ecl_phase_t;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// packs {extra periods T6..T1, coefs s4..s1, late write, refresh}
	function automatic logic [33:0] mk(input int a, b, c, d, e, f, s1, s2, s3, s4,
		input logic lw, rf);
		mk = {2'(f - 1), 2'(e - 1), 2'(d - 1), 2'(c - 1), 2'(b - 1), 2'(a - 1),
			5'(s4), 5'(s3), 5'(s2), 5'(s1), lw, rf};
	endfunction

	localparam logic [33:0] PRESET_DEFAULT = mk(4, 4, 4, 4, 4, 4, 31, 30, 30, 18, 1'b1, 1'b1);

	function automatic logic [17:0] to_lens(input logic [11:0] x);
		logic [17:0] l;
		l = '0;
		for (int i = 0; i < 6; i++)
		begin
			l[3 * i +: 3] = {1'b0, x[2 * i +: 2]} + 3'h1;
		end
		return l;
	endfunction

	function automatic logic [3:0] cycles(input logic [17:0] l);
		int s;
		s = 1;
		for (int i = 0; i < 6; i++)
		begin
			s = s + int'(l[3 * i +: 3]);
		end
		return 4'(s / 2);
	endfunction

endpackage

/* File: verilog/ecl_sync.sv */
// ecl_sync: three-flop synchroniser with agreement filter for one pin.
// assumes: the pin is asynchronous to i_clk; the output settles once the
// second and third flops agree.
`timescale 1ns/1ps
module ecl_sync
(
	input wire logic i_clk, // system clock
	input wire logic i_rst, // synchronous reset, high
	input wire logic i_async, // asynchronous pin
	output logic o_level, // filtered level
	output logic o_rise // one-cycle pulse on a filtered rise
);

	logic s1;
	logic s2;
	logic s3;
	wire agree = (s2 == s3);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			o_level <= 1'b0;
			o_rise <= 1'b0;
		end
		else
		begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			if (agree)
			begin
				o_level <= s3;
			end
			o_rise <= agree && s3 && !o_level;
		end
	end

endmodule // ecl_sync

/* File: test/ecl_far_model.sv */
// ecl_far_model: board wiring and boot rom seen from the loader's pins.
// assumes: loader lines and enable registered on i_clk; rom sits at EXT_BASE.
`timescale 1ns/1ps
module ecl_far_model
	import ecl_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_rst, // synchronous reset, high
	input wire logic [31:0] i_lines, // muxed address/data lines
	input wire logic i_oe, // line drive enable
	input wire logic [1:0] i_mode, // 0 wired to a line, 1 rom, 2 tied high
	input wire logic [4:0] i_line_sel, // line wired to the pin
	input wire logic [35:0] i_rom, // stored configuration bits
	output logic o_cfg, // configuration pin
	output logic o_wait, // wait request pin
	output logic [5:0] o_words // rom words addressed
);
	logic [31:0] ofs;
	logic [5:0] last;
	logic [4:0] wait_cnt;
	logic held;
	assign ofs = i_lines - EXT_BASE;
	// released line shows the inverse of its last driven level
	assign o_cfg = (i_mode == 2'h2) ? 1'b1 :
		(i_mode == 2'h0) ? (i_oe ? i_lines[i_line_sel] : ~held) :
		(last == 6'h3F) ? 1'b0 : ~i_rom[last];
	assign o_wait = (wait_cnt != 5'h00);
	always @(posedge i_clk)
	begin
		held <= i_rst ? 1'b1 : (i_oe ? i_lines[i_line_sel] : held);
		if (i_rst)
		begin
			last <= 6'h3F;
			o_words <= 6'h00;
			wait_cnt <= 5'h00;
		end
		else if (i_oe && ofs < 32'h90 && ofs[1:0] == 2'h0 && ofs[7:2] != last)
		begin
			last <= ofs[7:2];
			o_words <= o_words + 6'h01;
			wait_cnt <= 5'h14;
		end
		else if (wait_cnt != 5'h00)
			wait_cnt <= wait_cnt - 5'h01;
	end
endmodule // ecl_far_model

/* File: test/testbench.sv */
// testbench: runs the loader through preset and rom loads, checks results.
// assumes: ecl_far_model at the pins; APB answers without wait states.
`timescale 1ns/1ps
module testbench
	import ecl_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ref_clk = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [1:0] mode = 2'h2;
	logic [4:0] line_sel = 5'h00;
	logic [35:0] rom = 36'h000000000;
	logic cfg, wait_req, o_pready, o_pslverr, o_addr_data_oe, o_late_write, o_refresh_en;
	logic o_cfg_done;
	logic pclk_o;
	logic [31:0] o_prdata, o_addr_data_lines, q;
	logic [17:0] o_state_lens;
	logic [19:0] o_strobe_coefs;
	logic [7:0] o_refresh_ival;
	logic [3:0] o_proc_cycles;
	logic [5:0] words;
	logic e;
	int failures = 0;
	int total_checks = 0;
	int cycle_cnt = 0;
	always #12.5 i_clk = ~i_clk;
	always #130 i_ref_clk = ~i_ref_clk;
	ecl_loader dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ref_clk(i_ref_clk),
		.i_cfg_serial_in(cfg), .i_wait_request(wait_req), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_addr_data_lines(o_addr_data_lines), .o_addr_data_oe(o_addr_data_oe),
		.o_processor_clock_out(pclk_o), .o_state_lens(o_state_lens),
		.o_strobe_coefs(o_strobe_coefs), .o_late_write(o_late_write),
		.o_refresh_en(o_refresh_en), .o_refresh_ival(o_refresh_ival),
		.o_proc_cycles(o_proc_cycles), .o_cfg_done(o_cfg_done));
	ecl_far_model far_u (.i_clk(i_clk), .i_rst(i_rst), .i_lines(o_addr_data_lines),
		.i_oe(o_addr_data_oe), .i_mode(mode), .i_line_sel(line_sel), .i_rom(rom),
		.o_cfg(cfg), .o_wait(wait_req), .o_words(words));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [17:0] L(input int a, b, c, d, f, g);
		return {3'(g), 3'(f), 3'(d), 3'(c), 3'(b), 3'(a)};
	endfunction
	function automatic logic [19:0] C(input int a, b, c, d);
		return {5'(d), 5'(c), 5'(b), 5'(a)};
	endfunction
	task automatic stop_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge i_clk);
		end
		while (o_pready !== 1'b1);
		q = o_prdata;
		e = o_pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run(input logic [1:0] m, input logic [4:0] k, input logic [35:0] r);
		@(posedge i_clk);
		mode <= m;
		line_sel <= k;
		rom <= r;
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		chk(36'({o_cfg_done, o_addr_data_oe}), 36'h0);
		chk(36'(o_state_lens), 36'(L(4, 4, 4, 4, 4, 4)));
		@(posedge i_clk);
		i_rst <= 1'b0;
		while (o_cfg_done !== 1'b1)
		begin
			@(posedge i_clk);
		end
		#1;
	endtask
	task automatic expect_cfg(input logic [17:0] l, input logic [19:0] c, input logic lw,
		input logic en, input logic [7:0] iv, input logic [3:0] cy);
		chk(36'(o_state_lens), 36'(l));
		chk(36'(o_strobe_coefs), 36'(c));
		chk(36'({o_late_write, o_refresh_en, o_refresh_ival}), 36'({lw, en, iv}));
		chk(36'(o_proc_cycles), 36'(cy));
	endtask
	task automatic preset(input logic [4:0] k, input logic [17:0] l, input logic [19:0] c,
		input logic lw, input logic en, input logic [7:0] iv, input logic [3:0] cy);
		run(2'h0, k, 36'h000000000);
		expect_cfg(l, c, lw, en, iv, cy);
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	always @(posedge i_clk)
	begin
		cycle_cnt++;
		if (cycle_cnt == 60000)
		begin
			failures++;
			stop_test;
		end
	end
	initial
	begin
		run(2'h2, 5'h00, 36'h000000000);
		expect_cfg(L(4, 4, 4, 4, 4, 4), C(31, 30, 30, 18), 1'b1, 1'b1, 8'h48, 4'hC);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(36'(q[0]), 36'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk(36'({e, q}), 36'h100000000);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(36'(q[0]), 36'h1);
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(36'(q[0]), 36'h0);
		preset(5'h00, L(1, 1, 1, 1, 1, 1), C(30, 1, 3, 5), 1'b1, 1'b1, 8'h48, 4'h3);
		preset(5'h01, L(1, 2, 1, 1, 1, 2), C(30, 1, 2, 7), 1'b1, 1'b1, 8'h48, 4'h4);
		preset(5'h08, L(1, 1, 1, 1, 1, 1), C(30, 1, 2, 3), 1'b0, 1'b0, 8'h00, 4'h3);
		preset(5'h09, L(1, 1, 2, 1, 2, 1), C(30, 2, 5, 9), 1'b0, 1'b0, 8'h00, 4'h4);
		preset(5'h0B, L(3, 3, 3, 3, 3, 3), C(30, 2, 4, 13), 1'b1, 1'b1, 8'h48, 4'h9);
		preset(5'h0F, L(2, 1, 2, 3, 3, 3), C(8, 1, 2, 3), 1'b0, 1'b1, 8'h48, 4'h7);
		preset(5'h1F, L(4, 4, 4, 4, 4, 4), C(31, 30, 30, 18), 1'b1, 1'b1, 8'h48, 4'hC);
		preset(5'h14, L(4, 4, 4, 4, 4, 4), C(31, 30, 30, 18), 1'b1, 1'b1, 8'h48, 4'hC);
		run(2'h1, 5'h00, 36'hFFFFFFFFF);
		expect_cfg(L(4, 4, 4, 4, 4, 4), C(31, 31, 31, 31), 1'b1, 1'b1, 8'h48, 4'hC);
		chk(36'(words), 36'h24);
		run(2'h1, 5'h00, {1'b1, 1'b1, 2'h1, 5'h11, 5'h1F, 5'h00, 5'h05, 12'h4E4});
		expect_cfg(L(1, 2, 3, 4, 1, 2), C(5, 0, 31, 17), 1'b1, 1'b1, 8'h24, 4'h7);
		chk(36'(words), 36'h24);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(36'(q[3:2]), 36'h3);
		repeat (300) @(posedge i_clk);
		#1;
		chk(36'(o_state_lens), 36'(L(1, 2, 3, 4, 1, 2)));
		q[0] = pclk_o;
		@(posedge i_clk);
		#1;
		chk(36'(pclk_o), 36'(!q[0]));
		stop_test;
	end
endmodule // testbench
